// File: pms_map.svh
/*
  Constants of the power mode sequencer: timing, widths and reset values.
  Assumes a 25 MHz core clock; included by the package and the design files.
*/
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

// Core clock rate in kHz
`define PMS_CLOCK_KHZ        25000
// Wait from power control high until serial reception, in ms
`define PMS_SERIAL_WAIT_MS   5
// Wait in core clock cycles (exact, no rounding needed)
`define PMS_SERIAL_WAIT_CYC  (`PMS_SERIAL_WAIT_MS * `PMS_CLOCK_KHZ)
// Width of the wait counter
`define PMS_CNT_W            17
// Number of synchronised pins
`define PMS_PIN_W            2
// Bit positions of the pins in the synchroniser vector
`define PMS_PIN_PWR          0
`define PMS_PIN_RSTN         1
// Bit positions of the modes in the one-hot mode code
`define PMS_MODE_OFF_BIT     0
`define PMS_MODE_STANDBY_BIT 1
`define PMS_MODE_NORMAL_BIT  2
// Reset value of the synchronised pins: power control low, reset asserted
`define PMS_PIN_RST_VAL      2'h0
// Reset value of both regulator keep bits
`define PMS_KEEP_DEFAULT     1'h1

`endif

// File: pms_pkg.sv
/*
  Types of the power mode sequencer: mode encoding and state records.
  Assumes pms_map.svh is on the include path.
*/
`default_nettype none
`include "pms_map.svh"

package pms_pkg;

  typedef enum logic [2:0] {
    PMS_OFF     = 3'h1,
    PMS_STANDBY = 3'h2,
    PMS_NORMAL  = 3'h4
  } pms_mode_t;

  typedef struct packed {
    logic                  low;
    logic                  high;
  } pms_keep_t;

  typedef struct packed {
    logic [`PMS_PIN_W-1:0] s1;
    logic [`PMS_PIN_W-1:0] s2;
    logic [`PMS_PIN_W-1:0] s3;
    logic [`PMS_PIN_W-1:0] q;
  } pms_sync_t;

  typedef struct packed {
    pms_mode_t             mode;
    pms_keep_t             keep;
    logic [`PMS_CNT_W-1:0] cnt;
    logic                  ready;
    logic                  reg1_on;
    logic                  reg2_on;
    logic                  accept;
    logic                  defaults;
    logic                  force_low;
  } pms_state_t;

endpackage

`default_nettype wire

// File: pms_pin_sync.sv
/*
  Three-stage synchroniser with agreement filter for the external pins.
  Assumes asynchronous pin inputs; output level changes once stages two and three agree.
*/
`default_nettype none
`include "pms_map.svh"

module pms_pin_sync
  import pms_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_arst_n,
  input  wire logic [`PMS_PIN_W-1:0] i_pin,
  output var  logic [`PMS_PIN_W-1:0] o_level
);

  pms_sync_t st_r;
  pms_sync_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < `PMS_PIN_W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '{s1: `PMS_PIN_RST_VAL, s2: `PMS_PIN_RST_VAL, s3: `PMS_PIN_RST_VAL, q: `PMS_PIN_RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.q;

endmodule

`default_nettype wire

// File: pms_sequencer.sv
/*
  Power mode sequencer: OFF, Standby and Normal modes, regulator enables,
  serial gate, register default request and pin forcing under reset.
  Assumes the serial decoder sits on the same clock and offers keep bit writes
  on i_keep_we; power control and reset pins arrive asynchronously.
*/
//
// Operation
// R1 - Only a high power control pin brings the device out of OFF.
// R2 - Serial traffic ignored when power control low and a keep bit cleared.
// R3 - Power control falling with high rail keep set enters Standby.
// R4 - Standby refuses serial transfers, so no command leaves Standby.
// R5 - Power control rising in Standby returns to Normal.
// R6 - Standby never goes straight to OFF; host returns to Normal first.
// R7 - Power control high turns both regulators on regardless of keep bits.
// R8 - Reset pin low makes the device ignore all serial traffic.
// R9 - Serial reception opens only 5 ms after power control goes high.
// R10 - Reset pin low returns every register setting to default.
// R11 - Both regulator keep bits default to one.
// R12 - Reset before power control low keeps keep bits one, regulators stay on.
// R13 - Second regulator turning off returns all registers to default.
// R14 - Host enters OFF by clearing keep bits, lowering power, then reset.
// R15 - Under reset device drives interrupt and data low; host holds inputs low.
// R16 - Host holds reset high through Standby to keep register contents.
// R17 - Three-state mode machine evaluated each clock from pin and keep bits.
`default_nettype none
`include "pms_map.svh"

module pms_sequencer
  import pms_pkg::*;
#(
  parameter logic [`PMS_CNT_W-1:0] P_WAIT_CYC = `PMS_CNT_W'(`PMS_SERIAL_WAIT_CYC)
)
(
  input  wire logic  i_clock,
  input  wire logic  i_arst_n,
  input  wire logic  i_power_control_pin,
  input  wire logic  i_reset_low_pin_n,
  input  wire logic  i_keep_we,
  input  wire logic  i_low_rail_keep_bit,
  input  wire logic  i_high_rail_keep_bit,
  output var  logic  o_mode_off,
  output var  logic  o_mode_standby,
  output var  logic  o_mode_normal,
  output var  logic  o_first_regulator_on,
  output var  logic  o_second_regulator_on,
  output var  logic  o_low_rail_keep_bit,
  output var  logic  o_high_rail_keep_bit,
  output var  logic  o_serial_accept,
  output var  logic  o_reg_default,
  output var  logic  o_force_low
);

  logic [`PMS_PIN_W-1:0] pin_level;
  logic                  pwr;
  logic                  rstn;
  pms_state_t            st_r;
  pms_state_t            st_nxt;

  pms_pin_sync u_pin_sync (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .i_pin    ({i_reset_low_pin_n, i_power_control_pin}),
    .o_level  (pin_level)
  );

  assign pwr  = pin_level[`PMS_PIN_PWR];
  assign rstn = pin_level[`PMS_PIN_RSTN];

  always_comb begin
    st_nxt = st_r;

    // Mode machine
    case (st_r.mode) // R17
      PMS_OFF: begin
        if (pwr) begin // R1
          st_nxt.mode = PMS_NORMAL;
        end
      end
      PMS_NORMAL: begin
        if (!pwr && st_r.keep.high) begin // R3
          st_nxt.mode = PMS_STANDBY;
        end else if (!pwr) begin
          st_nxt.mode = PMS_OFF;
        end
      end
      PMS_STANDBY: begin
        // Only the power pin leaves Standby, and only toward Normal
        if (pwr) begin // R5 R6 R4
          st_nxt.mode = PMS_NORMAL;
        end
      end
      default: begin
        st_nxt.mode = PMS_OFF;
      end
    endcase

    // Startup wait, restarted whenever power control drops
    if (!pwr) begin // R9
      st_nxt.cnt   = '0;
      st_nxt.ready = 1'h0;
    end else if (st_r.cnt < P_WAIT_CYC - `PMS_CNT_W'(1)) begin
      st_nxt.cnt   = st_r.cnt + `PMS_CNT_W'(1);
    end else begin
      st_nxt.ready = 1'h1;
    end

    // Keep bit writes from the serial side, only while accepted
    if (st_r.accept && i_keep_we) begin
      st_nxt.keep.low  = i_low_rail_keep_bit;
      st_nxt.keep.high = i_high_rail_keep_bit;
    end

    // Defaults on reset pin or when the second regulator goes off
    st_nxt.defaults = !rstn || (st_nxt.mode == PMS_OFF); // R10 R13
    if (st_nxt.defaults) begin
      st_nxt.keep.low  = `PMS_KEEP_DEFAULT; // R11 R12
      st_nxt.keep.high = `PMS_KEEP_DEFAULT;
    end

    // Regulators: pin high forces both on; keep bits hold them in Standby
    st_nxt.reg1_on = pwr || (st_r.keep.low && (st_nxt.mode != PMS_OFF)); // R7
    st_nxt.reg2_on = pwr || (st_r.keep.high && (st_nxt.mode != PMS_OFF)); // R7 R13

    // Serial gate
    st_nxt.accept = (st_nxt.mode == PMS_NORMAL) && st_nxt.ready && rstn // R4 R8 R9
                    && !(!pwr && !(st_r.keep.low && st_r.keep.high)); // R2

    st_nxt.force_low = !rstn; // R15
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '{mode:      PMS_OFF,
                keep:      '{low: `PMS_KEEP_DEFAULT, high: `PMS_KEEP_DEFAULT},
                cnt:       '0,
                ready:     1'h0,
                reg1_on:   1'h0,
                reg2_on:   1'h0,
                accept:    1'h0,
                defaults:  1'h1,
                force_low: 1'h1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_mode_off            = st_r.mode[`PMS_MODE_OFF_BIT];
  assign o_mode_standby        = st_r.mode[`PMS_MODE_STANDBY_BIT];
  assign o_mode_normal         = st_r.mode[`PMS_MODE_NORMAL_BIT];
  assign o_first_regulator_on  = st_r.reg1_on;
  assign o_second_regulator_on = st_r.reg2_on;
  assign o_low_rail_keep_bit   = st_r.keep.low;
  assign o_high_rail_keep_bit  = st_r.keep.high;
  assign o_serial_accept       = st_r.accept;
  assign o_reg_default         = st_r.defaults;
  assign o_force_low           = st_r.force_low;

  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  off_hold_a: assert property ( // R1
    (st_r.mode == PMS_OFF) && !pwr |=> (st_r.mode == PMS_OFF))
    else $error("left OFF without power control high");

  keep_gate_a: assert property ( // R2
    !pwr && !(st_r.keep.low && st_r.keep.high) |=> !o_serial_accept)
    else $error("serial accepted with power low and keep bit cleared");

  standby_entry_a: assert property ( // R3
    (st_r.mode == PMS_NORMAL) && !pwr && st_r.keep.high |=> o_mode_standby)
    else $error("Standby not entered");

  standby_gate_a: assert property ( // R4
    o_mode_standby |-> !o_serial_accept)
    else $error("serial accepted in Standby");

  standby_exit_a: assert property ( // R5
    o_mode_standby && pwr |=> o_mode_normal)
    else $error("Standby not left on power high");

  no_direct_off_a: assert property ( // R6
    o_mode_standby |=> !o_mode_off)
    else $error("Standby went straight to OFF");

  reg_forced_a: assert property ( // R7
    pwr |=> o_first_regulator_on && o_second_regulator_on)
    else $error("regulator off while power control high");

  reset_gate_a: assert property ( // R8
    !rstn |=> !o_serial_accept && o_reg_default)
    else $error("serial accepted during reset");

  wait_start_a: assert property ( // R9
    !pwr ##1 pwr |=> !o_serial_accept [*8])
    else $error("serial accepted too early after power high");

  wait_open_a: assert property ( // R9
    o_serial_accept |-> st_r.ready && (st_r.cnt == P_WAIT_CYC - `PMS_CNT_W'(1)))
    else $error("serial accepted before wait elapsed");

  reset_default_a: assert property ( // R10
    !rstn |=> o_low_rail_keep_bit && o_high_rail_keep_bit)
    else $error("keep bits not default under reset");

  early_reset_a: assert property ( // R12
    !rstn ##1 (!pwr && o_mode_normal) |=> o_second_regulator_on && o_mode_standby)
    else $error("regulator off after reset before power low");

  reg_off_default_a: assert property ( // R13
    $fell(o_second_regulator_on) |-> o_reg_default && o_mode_off)
    else $error("second regulator off without defaults");

  force_low_a: assert property ( // R15
    !rstn |=> o_force_low)
    else $error("outputs not forced low under reset");

  // Keep bit path
  keep_write_a: assert property ( // R2
    o_serial_accept && i_keep_we && rstn && pwr
      |=> (o_low_rail_keep_bit == $past(i_low_rail_keep_bit))
          && (o_high_rail_keep_bit == $past(i_high_rail_keep_bit)))
    else $error("accepted keep write did not land");

  keep_refuse_a: assert property ( // R9
    !o_serial_accept && rstn && pwr |=> $stable(o_low_rail_keep_bit) && $stable(o_high_rail_keep_bit))
    else $error("keep bits changed while serial gate closed");

  standby_keep_a: assert property ( // R4
    o_mode_standby && rstn && !pwr |=> $stable(o_low_rail_keep_bit) && $stable(o_high_rail_keep_bit))
    else $error("keep bits changed in Standby");

  // Regulator and default levels
  standby_regs_a: assert property ( // R3
    o_mode_standby |-> o_second_regulator_on)
    else $error("second regulator off in Standby");

  standby_reg1_a: assert property ( // R7
    o_mode_standby |-> (o_first_regulator_on == $past(o_low_rail_keep_bit)))
    else $error("first regulator does not follow its keep bit in Standby");

  off_regs_a: assert property ( // R13
    o_mode_off |-> !o_first_regulator_on && !o_second_regulator_on && o_reg_default)
    else $error("regulator on or defaults released in OFF");

  off_keep_a: assert property ( // R11
    o_mode_off |-> o_low_rail_keep_bit && o_high_rail_keep_bit)
    else $error("keep bits not default in OFF");

  default_release_a: assert property ( // R10
    rstn && pwr |=> !o_reg_default)
    else $error("defaults held without cause");

  force_release_a: assert property ( // R15
    rstn |=> !o_force_low)
    else $error("outputs forced low without reset");

  // Mode holds and exits
  power_rise_a: assert property ( // R1
    o_mode_off && pwr |=> o_mode_normal && o_first_regulator_on && o_second_regulator_on)
    else $error("OFF not left on power control high");

  normal_hold_a: assert property ( // R17
    o_mode_normal && pwr |=> o_mode_normal)
    else $error("Normal left while power control high");

  standby_hold_a: assert property ( // R4
    o_mode_standby && !pwr |=> o_mode_standby)
    else $error("Standby left without power control high");

  off_entry_a: assert property ( // R13
    o_mode_normal && !pwr && !o_high_rail_keep_bit |=> o_mode_off && !o_second_regulator_on)
    else $error("OFF not entered with high rail keep cleared");

  // Serial gate timing
  power_low_gate_a: assert property ( // R9
    !pwr |=> !o_serial_accept)
    else $error("serial accepted with power control low");

  standby_wait_a: assert property ( // R9
    o_mode_standby && pwr |=> !o_serial_accept)
    else $error("serial accepted at once after Standby");

  accept_rise_a: assert property ( // R9
    $rose(o_serial_accept) |-> $past(pwr, 8))
    else $error("serial gate opened without a power control wait");

  accept_hold_a: assert property ( // R9
    o_serial_accept && pwr && rstn |=> o_serial_accept)
    else $error("serial gate closed without cause");

  cover_power_up_c: cover property (
    o_mode_off ##1 o_mode_normal ##[1:8] pwr);

  cover_standby_c: cover property (
    o_mode_normal ##1 o_mode_standby ##[1:20] o_mode_normal);

  cover_off_entry_c: cover property (
    o_mode_normal && !o_high_rail_keep_bit ##1 o_mode_off);

  cover_accept_c: cover property (
    $rose(o_serial_accept));

  cover_reset_standby_c: cover property (
    o_mode_standby && o_reg_default);

endmodule

`default_nettype wire

// File: pms_host_model.sv
/*
  Host model: drives power control, reset pin and keep bit writes.
  Assumes the sequencer clock; every change lands at a falling edge.
*/
`default_nettype none

module pms_host_model (
  input  wire logic i_clock,
  output var  logic o_power,
  output var  logic o_rst_n,
  output var  logic o_keep_we,
  output var  logic o_keep_low,
  output var  logic o_keep_high
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle low, reset held
  initial begin
    o_power = 1'h0;
    o_rst_n = 1'h0;
    o_keep_we = 1'h0;
    o_keep_low = 1'h0;
    o_keep_high = 1'h0;
  end

  task automatic set_power(input logic v);
    @(negedge i_clock);
    o_power = v;
  endtask

  task automatic set_reset_n(input logic v);
    @(negedge i_clock);
    o_rst_n = v;
  endtask

  task automatic keep_write(input logic lo, input logic hi);
    @(negedge i_clock);
    o_keep_we = 1'h1;
    o_keep_low = lo;
    o_keep_high = hi;
    @(negedge i_clock);
    o_keep_we = 1'h0;
    o_keep_low = 1'h0;
    o_keep_high = 1'h0;
  endtask
endmodule

`default_nettype wire

// File: testbench.sv
/*
  Self-checking bench of the power mode sequencer with a host model.
  Assumes the short serial wait parameter; pins settle within 8 cycles.
*/
`default_nettype none
`include "pms_map.svh"

module testbench
  import pms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [`PMS_CNT_W-1:0] P_WAIT = `PMS_CNT_W'(20);
  logic        i_clock;
  logic        i_arst_n;
  logic        pwr, rst_n, kwe, klo, khi;
  logic        m_off, m_sb, m_nm, reg1, reg2, olo, ohi, acc, dflt, frc;
  logic        m_pwr, m_rstn, m_lo, m_hi, m_acc;
  logic [31:0] rnd;
  int          errors, comparisons, n, m_mode;

  pms_host_model host (.i_clock(i_clock), .o_power(pwr), .o_rst_n(rst_n), .o_keep_we(kwe),
    .o_keep_low(klo), .o_keep_high(khi));

  pms_sequencer #(.P_WAIT_CYC(P_WAIT)) DUT (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_power_control_pin(pwr), .i_reset_low_pin_n(rst_n), .i_keep_we(kwe),
    .i_low_rail_keep_bit(klo), .i_high_rail_keep_bit(khi), .o_mode_off(m_off),
    .o_mode_standby(m_sb), .o_mode_normal(m_nm), .o_first_regulator_on(reg1),
    .o_second_regulator_on(reg2), .o_low_rail_keep_bit(olo), .o_high_rail_keep_bit(ohi),
    .o_serial_accept(acc), .o_reg_default(dflt), .o_force_low(frc));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_flag(input string nm, input logic e, input logic s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic chk_mode(input logic [2:0] e, input logic [2:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] mode expected %b seen %b", e, s);
    end
  endtask

  // Model: mode 0 off, 1 standby, 2 normal
  task automatic expect_all();
    chk_mode(3'(1 << m_mode), {m_nm, m_sb, m_off});
    chk_flag("reg1", m_pwr | (m_mode != 0 && m_lo), reg1);
    chk_flag("reg2", m_pwr | (m_mode != 0 && m_hi), reg2);
    chk_flag("keep_low", m_lo, olo);
    chk_flag("keep_high", m_hi, ohi);
    chk_flag("default", !m_rstn || m_mode == 0, dflt);
    chk_flag("force_low", !m_rstn, frc);
    chk_flag("accept", m_acc && m_mode == 2 && m_rstn, acc);
  endtask

  task automatic m_power(input logic v);
    m_pwr = v;
    m_acc = 1'h0;
    host.set_power(v);
    if (v)
      m_mode = 2;
    else if (m_mode == 2) begin
      m_mode = m_hi ? 1 : 0;
      if (!m_hi) begin
        m_lo = 1'h1;
        m_hi = 1'h1;
      end
    end
    repeat (8) @(negedge i_clock);
    expect_all();
  endtask

  task automatic m_reset(input logic v);
    m_rstn = v;
    host.set_reset_n(v);
    if (!v) begin
      m_lo = 1'h1;
      m_hi = 1'h1;
    end
    repeat (8) @(negedge i_clock);
    expect_all();
  endtask

  task automatic m_keep(input logic lo, input logic hi);
    host.keep_write(lo, hi);
    @(negedge i_clock);
    if (m_acc && m_mode == 2 && m_rstn) begin
      m_lo = lo;
      m_hi = hi;
    end
    expect_all();
  endtask

  // Counts from the power pin drive; pre cycles already passed
  task automatic wait_accept(input int pre);
    n = 0;
    while (acc !== 1'h1 && n < 60) begin
      @(negedge i_clock);
      n++;
    end
    m_acc = 1'h1;
    chk_flag("accept", 1'h1, acc);
    chk_flag("wait", 1'h1, pre + n >= int'(P_WAIT));
    chk_flag("wait_max", 1'h1, pre + n <= int'(P_WAIT) + 6);
    if (n >= 60)
      tally_and_finish();
  endtask

  initial begin
    i_clock = 1'h0;
    forever #20 i_clock = ~i_clock;
  end

  initial begin
    errors = 0;
    comparisons = 0;
    rnd = 32'hb67c7416;
    m_mode = 0;
    m_pwr = 1'h0;
    m_rstn = 1'h0;
    m_lo = 1'h1;
    m_hi = 1'h1;
    m_acc = 1'h0;
    i_arst_n = 1'h0;
    repeat (10) @(negedge i_clock);
    i_arst_n = 1'h1;
    repeat (8) @(negedge i_clock);
    expect_all();
    m_reset(1'h1);
    m_power(1'h1);
    m_keep(1'h0, 1'h0);
    wait_accept(11);
    $display("test power_up done");
    rnd = lfsr(rnd);
    m_keep(rnd[0], 1'h1);
    rnd = lfsr(rnd);
    m_keep(rnd[1], 1'h1);
    $display("test keep_write done");
    m_power(1'h0);
    m_keep(1'h0, 1'h0);
    m_power(1'h1);
    wait_accept(8);
    $display("test standby done");
    m_reset(1'h0);
    m_power(1'h0);
    m_reset(1'h1);
    m_power(1'h1);
    wait_accept(8);
    $display("test reset_pin done");
    m_keep(1'h0, 1'h0);
    m_power(1'h0);
    m_keep(1'h0, 1'h0);
    m_reset(1'h0);
    repeat (20) @(negedge i_clock);
    expect_all();
    $display("test off done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
